/* File: dv/dtc_pins.sv */
// model of the external interrupt and count input pins
`timescale 1ns/1ps
`default_nettype none
module dtc_pins (
	input wire logic pclk,
	input wire logic [3:0] want,
	output logic ext_irq_a_pin,
	output logic ext_irq_b_pin,
	output logic count_input_a_pin,
	output logic count_input_b_pin
);
	// pins idle high and change just after a clock edge
	initial {count_input_b_pin, count_input_a_pin, ext_irq_b_pin, ext_irq_a_pin} = 4'hf;
	always @(posedge pclk) begin
		{count_input_b_pin, count_input_a_pin, ext_irq_b_pin, ext_irq_a_pin} <= want;
	end
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the dual timer block
`include "dtc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench
	import dtc_pkg::*;
;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, irq, ea, eb, ca, cb, e;
	logic [3:0] want = 4'hf;
	logic [7:0] q;
	int n_mismatch = 0, samples_checked = 0, cyc = 0;
	dtc_timer i_dtc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ext_irq_a_pin(ea), .ext_irq_b_pin(eb),
		.count_input_a_pin(ca), .count_input_b_pin(cb), .irq(irq));
	dtc_pins i_dtc_pins (.pclk(pclk), .want(want), .ext_irq_a_pin(ea), .ext_irq_b_pin(eb),
		.count_input_a_pin(ca), .count_input_b_pin(cb));
	initial begin
		forever #25 pclk = ~pclk;
	end
	task automatic stop_test();
		$display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc > 20000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		samples_checked++;
		if (g !== x) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, g, x);
		end
	endtask
	// one apb transfer; held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata[7:0];
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1, idx, d);
	endtask
	task automatic rc(input logic [7:0] idx, input logic [7:0] x);
		apb(0, idx, 8'h00);
		chk(q, x);
	endtask
	task automatic t_reset();
		for (int i = 0; i < 6; i++) rc(8'h88 + 8'(i), 8'h00);
		rc(`DTC_IDX_DIVIDE, `DTC_RESET_DIVIDE);
		apb(0, 8'h99, 8'h00);
		chk({7'h0, e}, 8'h01);
		wr(`DTC_IDX_DIVIDE, 8'h00);
		wr(`DTC_IDX_A_LO, 8'h5a);
		rc(`DTC_IDX_A_LO, 8'h5a);
	endtask
	task automatic t_ovf();
		wr(`DTC_IDX_MODE, 8'h01);
		wr(`DTC_IDX_A_LO, 8'hfe);
		wr(`DTC_IDX_A_HI, 8'hff);
		wr(`DTC_IDX_IRQ_MASK, 8'h02);
		wr(`DTC_IDX_CTRL, 8'h10);
		repeat (8) @(posedge pclk);
		chk({7'h0, irq}, 8'h01);
		rc(`DTC_IDX_CTRL, 8'h30);
		wr(`DTC_IDX_CTRL, 8'h20);
		apb(0, `DTC_IDX_A_LO, 8'h00);
		rc(`DTC_IDX_A_LO, q);
		wr(`DTC_IDX_VECTOR, 8'h02);
		rc(`DTC_IDX_CTRL, 8'h00);
		wr(`DTC_IDX_IRQ_STAT, 8'h02);
		@(posedge pclk);
		chk({7'h0, irq}, 8'h00);
	endtask
	task automatic t_modes();
		wr(`DTC_IDX_MODE, 8'h33);
		wr(`DTC_IDX_B_LO, 8'h11);
		wr(`DTC_IDX_A_HI, 8'hff);
		wr(`DTC_IDX_CTRL, 8'h40);
		repeat (8) @(posedge pclk);
		rc(`DTC_IDX_CTRL, 8'hc0);
		rc(`DTC_IDX_B_LO, 8'h11);
		wr(`DTC_IDX_MODE, 8'h02);
		wr(`DTC_IDX_A_HI, 8'hf0);
		wr(`DTC_IDX_A_LO, 8'hff);
		wr(`DTC_IDX_CTRL, 8'h10);
		wr(`DTC_IDX_CTRL, 8'h00);
		rc(`DTC_IDX_A_HI, 8'hf0);
		apb(0, `DTC_IDX_A_LO, 8'h00);
		chk(q & 8'hf0, 8'hf0);
		rc(`DTC_IDX_IRQ_STAT, 8'h0a);
	endtask
	task automatic t_pins();
		wr(`DTC_IDX_MODE, 8'h05);
		wr(`DTC_IDX_A_LO, 8'h00);
		wr(`DTC_IDX_CTRL, 8'h11);
		for (int i = 0; i < 6; i++) begin
			want[2] <= i[0];
			repeat (6) @(posedge pclk);
		end
		rc(`DTC_IDX_A_LO, 8'h03);
		want[0] <= 0;
		repeat (6) @(posedge pclk);
		rc(`DTC_IDX_CTRL, 8'h13);
		wr(`DTC_IDX_VECTOR, 8'h01);
		rc(`DTC_IDX_CTRL, 8'h11);
		wr(`DTC_IDX_MODE, 8'h09);
		wr(`DTC_IDX_CTRL, 8'h10);
		wr(`DTC_IDX_A_LO, 8'h00);
		rc(`DTC_IDX_CTRL, 8'h12);
		rc(`DTC_IDX_A_LO, 8'h00);
		want[0] <= 1;
		repeat (6) @(posedge pclk);
		rc(`DTC_IDX_CTRL, 8'h10);
		apb(0, `DTC_IDX_A_LO, 8'h00);
		chk({7'h0, q != 8'h00}, 8'h01);
	endtask
	// 13-bit mode with a three-clock machine cycle
	task automatic t_div();
		wr(`DTC_IDX_CTRL, 8'h00);
		wr(`DTC_IDX_MODE, 8'h00);
		wr(`DTC_IDX_A_HI, 8'h00);
		wr(`DTC_IDX_A_LO, 8'h1e);
		wr(`DTC_IDX_DIVIDE, 8'h02);
		wr(`DTC_IDX_CTRL, 8'h10);
		repeat (30) @(posedge pclk);
		wr(`DTC_IDX_CTRL, 8'h00);
		rc(`DTC_IDX_A_HI, 8'h01);
		apb(0, `DTC_IDX_A_LO, 8'h00);
		chk({7'h0, q >= 8'h08 && q <= 8'h0a}, 8'h01);
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		t_reset();
		t_ovf();
		t_modes();
		t_pins();
		t_div();
		stop_test();
	end
endmodule
`default_nettype wire

/* File: include/dtc_map.svh */
// register offsets, field positions and reset values for the dual timer block
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH
`define DTC_IDX_CTRL 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_A_LO 8'h8a
`define DTC_IDX_B_LO 8'h8b
`define DTC_IDX_A_HI 8'h8c
`define DTC_IDX_B_HI 8'h8d
`define DTC_IDX_IRQ_STAT 8'h90
`define DTC_IDX_IRQ_MASK 8'h91
`define DTC_IDX_VECTOR 8'h92
`define DTC_IDX_DIVIDE 8'h93
`define DTC_CTRL_B_OVF 7
`define DTC_CTRL_B_RUN 6
`define DTC_CTRL_A_OVF 5
`define DTC_CTRL_A_RUN 4
`define DTC_CTRL_XB_FLAG 3
`define DTC_CTRL_XB_TYPE 2
`define DTC_CTRL_XA_FLAG 1
`define DTC_CTRL_XA_TYPE 0
`define DTC_MODE_A_GATE 3
`define DTC_MODE_A_PIN 2
`define DTC_MODE_B_GATE 7
`define DTC_MODE_B_PIN 6
`define DTC_RESET_BYTE 8'h00
`define DTC_RESET_DIVIDE 8'h0b
`endif

/* File: include/dtc_pkg.sv */
// types shared by the dual timer block
package dtc_pkg;
	typedef enum logic [1:0] {
		DTC_MODE_13BIT = 2'b00,
		DTC_MODE_16BIT = 2'b01,
		DTC_MODE_RELOAD = 2'b10,
		DTC_MODE_SPLIT = 2'b11
	} dtc_mode_t;
	typedef enum logic [1:0] {
		DTC_APB_IDLE = 2'b00,
		DTC_APB_SETUP = 2'b01,
		DTC_APB_ACCESS = 2'b10
	} dtc_apb_state_t;
endpackage

/* File: src/dtc_timer.sv */
// dual 16-bit timer/counter with external interrupt flags behind an apb slave
//
// Chosen here: the APB slave port.
`include "dtc_map.svh"
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// [RQ1] overflow sets flag; vector acknowledge clears it
// [RQ2] run bit starts and stops each timer
// [RQ3] falling edge mode flags high-then-low samples
// [RQ4] low level mode flag follows inverted pin
// [RQ5] type bit chooses edge or level trigger
// [RQ6] gate bit requires ext pin high too
// [RQ7] select bit picks pin or machine cycle
// [RQ8] mode 0 13-bit, mode 1 16-bit
// [RQ9] mode 2 low byte reloads from high
// [RQ10] split mode: low byte uses timer a controls
// [RQ11] split mode: high byte uses timer b run/flag
// [RQ12] timer b mode 3 holds its count
// [RQ13] count bytes reset zero, software readable writable
// [RQ14] machine cycle is clock divided by setting plus one
// [RQ15] counter mode counts sampled falling pin edges
// [RQ16] timer mode counts one per machine cycle
module dtc_timer
	import dtc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_irq_a_pin,
	input wire logic ext_irq_b_pin,
	input wire logic count_input_a_pin,
	input wire logic count_input_b_pin,
	output logic irq
);
	logic [3:0] sync1_ff, sync2_ff, prev_ff;
	logic [7:0] ctrl_ff, mode_ff, a_lo_ff, a_hi_ff, b_lo_ff, b_hi_ff;
	logic [7:0] stat_ff, mask_ff, div_ff, divcnt_ff, prdata_ff;
	logic [7:0] nxt_ctrl, nxt_a_lo, nxt_a_hi, nxt_b_lo, nxt_b_hi, nxt_stat;
	// pins: 0 ext a, 1 ext b, 2 count a, 3 count b
	wire [3:0] pins = {count_input_b_pin, count_input_a_pin, ext_irq_b_pin, ext_irq_a_pin};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 4'hf;
			sync2_ff <= 4'hf;
		end else begin
			sync1_ff <= pins;
			sync2_ff <= sync1_ff;
		end
	end
	// machine cycle tick
	wire tick = (divcnt_ff == 8'h00); // RQ14
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divcnt_ff <= 8'h00;
			prev_ff <= 4'hf;
		end else begin
			divcnt_ff <= tick ? div_ff : divcnt_ff - 8'h01; // RQ14
			if (tick)
				prev_ff <= sync2_ff;
		end
	end
	wire [3:0] fall = prev_ff & ~sync2_ff;
	// apb decode
	wire [7:0] idx = paddr[9:2];
	wire acc = psel && penable;
	wire hit_ctrl = idx == `DTC_IDX_CTRL;
	wire hit_mode = idx == `DTC_IDX_MODE;
	wire hit_alo = idx == `DTC_IDX_A_LO;
	wire hit_blo = idx == `DTC_IDX_B_LO;
	wire hit_ahi = idx == `DTC_IDX_A_HI;
	wire hit_bhi = idx == `DTC_IDX_B_HI;
	wire hit_stat = idx == `DTC_IDX_IRQ_STAT;
	wire hit_mask = idx == `DTC_IDX_IRQ_MASK;
	wire hit_vec = idx == `DTC_IDX_VECTOR;
	wire hit_div = idx == `DTC_IDX_DIVIDE;
	wire mapped = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) && (hit_ctrl || hit_mode || hit_alo ||
		hit_blo || hit_ahi || hit_bhi || hit_stat || hit_mask || hit_vec || hit_div);
	// writes to unmapped or misaligned words are dropped
	wire wr = acc && pwrite && pstrb[0] && mapped;
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign prdata = {24'h000000, prdata_ff};
	wire [7:0] rd_mux = hit_ctrl ? ctrl_ff : hit_mode ? mode_ff : hit_alo ? a_lo_ff : hit_blo ? b_lo_ff :
		hit_ahi ? a_hi_ff : hit_bhi ? b_hi_ff : hit_stat ? stat_ff : hit_mask ? mask_ff :
		hit_div ? div_ff : 8'h00;
	// acknowledge strobes: 0 ext a, 1 timer a, 2 ext b, 3 timer b
	wire [3:0] ack = (wr && hit_vec && mapped) ? pwdata[3:0] : 4'h0;
	// enables and count events
	dtc_mode_t mode_a, mode_b;
	assign mode_a = dtc_mode_t'(mode_ff[1:0]);
	assign mode_b = dtc_mode_t'(mode_ff[5:4]);
	wire split = mode_a == DTC_MODE_SPLIT;
	wire run_a = ctrl_ff[`DTC_CTRL_A_RUN] && (!mode_ff[`DTC_MODE_A_GATE] || sync2_ff[0]); // RQ2 RQ6
	wire run_b = ctrl_ff[`DTC_CTRL_B_RUN] && (!mode_ff[`DTC_MODE_B_GATE] || sync2_ff[1]) &&
		mode_b != DTC_MODE_SPLIT; // RQ2 RQ6 RQ12
	wire ev_a = run_a && (mode_ff[`DTC_MODE_A_PIN] ? (tick && fall[2]) : tick); // RQ7 RQ15 RQ16
	wire ev_b = run_b && (mode_ff[`DTC_MODE_B_PIN] ? (tick && fall[3]) : tick); // RQ7 RQ15 RQ16
	wire ev_ah = ctrl_ff[`DTC_CTRL_B_RUN] && tick; // RQ11
	logic ovf_a, ovf_b, ovf_ah;
	// one timer step; returns {overflow, hi, lo}
	function automatic logic [16:0] dtc_step(input dtc_mode_t m, input logic [7:0] hi, input logic [7:0] lo);
		logic [16:0] r;
		r = {1'b0, hi, lo};
		case (m)
			DTC_MODE_13BIT: begin
				if (lo[4:0] == 5'h1f) // RQ8
					r = {hi == 8'hff, hi + 8'h01, lo[7:5], 5'h00};
				else
					r = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
			end
			DTC_MODE_16BIT: r = {1'b0, hi, lo} + 17'h00001; // RQ8
			DTC_MODE_RELOAD: r = (lo == 8'hff) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01}; // RQ9
			DTC_MODE_SPLIT: r = {lo == 8'hff, hi, lo + 8'h01}; // RQ10
			default: r = {1'b0, hi, lo};
		endcase
		return r;
	endfunction
	logic [16:0] step_a, step_b;
	assign step_a = dtc_step(mode_a, a_hi_ff, a_lo_ff);
	assign step_b = dtc_step(mode_b, b_hi_ff, b_lo_ff);
	always_comb begin
		nxt_a_lo = a_lo_ff;
		nxt_a_hi = a_hi_ff;
		nxt_b_lo = b_lo_ff;
		nxt_b_hi = b_hi_ff;
		ovf_a = 1'b0;
		ovf_b = 1'b0;
		ovf_ah = 1'b0;
		if (ev_a) begin
			ovf_a = step_a[16]; // RQ1
			nxt_a_lo = step_a[7:0];
			if (!split)
				nxt_a_hi = step_a[15:8];
		end
		if (split && ev_ah) begin
			ovf_ah = a_hi_ff == 8'hff; // RQ11
			nxt_a_hi = a_hi_ff + 8'h01;
		end
		if (ev_b) begin
			ovf_b = step_b[16]; // RQ1
			nxt_b_lo = step_b[7:0];
			nxt_b_hi = step_b[15:8];
		end
		if (wr && hit_alo)
			nxt_a_lo = pwdata[7:0]; // RQ13
		if (wr && hit_ahi)
			nxt_a_hi = pwdata[7:0]; // RQ13
		if (wr && hit_blo)
			nxt_b_lo = pwdata[7:0]; // RQ13
		if (wr && hit_bhi)
			nxt_b_hi = pwdata[7:0]; // RQ13
	end
	wire set_ta = ovf_a;
	wire set_tb = split ? ovf_ah : ovf_b; // RQ11
	wire set_xa = tick && fall[0];
	wire set_xb = tick && fall[1];
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (wr && hit_ctrl)
			nxt_ctrl = pwdata[7:0];
		if (ack[1])
			nxt_ctrl[`DTC_CTRL_A_OVF] = 1'b0; // RQ1
		if (ack[3])
			nxt_ctrl[`DTC_CTRL_B_OVF] = 1'b0; // RQ1
		if (ack[0])
			nxt_ctrl[`DTC_CTRL_XA_FLAG] = 1'b0; // RQ3
		if (ack[2])
			nxt_ctrl[`DTC_CTRL_XB_FLAG] = 1'b0; // RQ3
		if (set_ta)
			nxt_ctrl[`DTC_CTRL_A_OVF] = 1'b1; // RQ1
		if (set_tb)
			nxt_ctrl[`DTC_CTRL_B_OVF] = 1'b1; // RQ1
		if (ctrl_ff[`DTC_CTRL_XA_TYPE]) begin // RQ5
			if (set_xa)
				nxt_ctrl[`DTC_CTRL_XA_FLAG] = 1'b1; // RQ3
		end else if (tick) begin
			nxt_ctrl[`DTC_CTRL_XA_FLAG] = !sync2_ff[0]; // RQ4
		end
		if (ctrl_ff[`DTC_CTRL_XB_TYPE]) begin // RQ5
			if (set_xb)
				nxt_ctrl[`DTC_CTRL_XB_FLAG] = 1'b1; // RQ3
		end else if (tick) begin
			nxt_ctrl[`DTC_CTRL_XB_FLAG] = !sync2_ff[1]; // RQ4
		end
	end
	// sticky status: 0 ext a, 1 timer a, 2 ext b, 3 timer b
	wire [3:0] ev_set = {set_tb, set_xb && ctrl_ff[`DTC_CTRL_XB_TYPE], set_ta, set_xa && ctrl_ff[`DTC_CTRL_XA_TYPE]};
	wire [3:0] stat_clr = (wr && hit_stat) ? pwdata[3:0] : 4'h0;
	assign nxt_stat = {4'h0, (stat_ff[3:0] & ~stat_clr) | ev_set};
	assign irq = |(stat_ff & mask_ff);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff <= `DTC_RESET_BYTE;
			mode_ff <= `DTC_RESET_BYTE;
			a_lo_ff <= `DTC_RESET_BYTE;
			a_hi_ff <= `DTC_RESET_BYTE;
			b_lo_ff <= `DTC_RESET_BYTE;
			b_hi_ff <= `DTC_RESET_BYTE;
			stat_ff <= `DTC_RESET_BYTE;
			mask_ff <= `DTC_RESET_BYTE;
			div_ff <= `DTC_RESET_DIVIDE;
			prdata_ff <= `DTC_RESET_BYTE;
		end else begin
			ctrl_ff <= nxt_ctrl;
			a_lo_ff <= nxt_a_lo;
			a_hi_ff <= nxt_a_hi;
			b_lo_ff <= nxt_b_lo;
			b_hi_ff <= nxt_b_hi;
			stat_ff <= nxt_stat;
			if (wr && hit_mode)
				mode_ff <= pwdata[7:0];
			if (wr && hit_mask)
				mask_ff <= {4'h0, pwdata[3:0]};
			if (wr && hit_div)
				div_ff <= pwdata[7:0];
			if (psel && !penable && !pwrite)
				prdata_ff <= mapped ? rd_mux : 8'h00;
		end
	end
	property p_ack_clears_ta;
		@(posedge pclk) disable iff (!presetn)
		(ack[1] && !set_ta) |=> !ctrl_ff[`DTC_CTRL_A_OVF];
	endproperty
	a_ack_clears_ta: assert property (p_ack_clears_ta) else $error("timer a flag not cleared"); // RQ1
	property p_stop_holds;
		@(posedge pclk) disable iff (!presetn)
		(!ctrl_ff[`DTC_CTRL_A_RUN] && !split && !(wr && (hit_alo || hit_ahi))) |=> $stable(a_lo_ff);
	endproperty
	a_stop_holds: assert property (p_stop_holds) else $error("stopped timer a moved"); // RQ2
	property p_edge_sets;
		@(posedge pclk) disable iff (!presetn)
		(ctrl_ff[`DTC_CTRL_XA_TYPE] && set_xa) |=> ctrl_ff[`DTC_CTRL_XA_FLAG];
	endproperty
	a_edge_sets: assert property (p_edge_sets) else $error("edge flag missed"); // RQ3
	property p_level_follows;
		@(posedge pclk) disable iff (!presetn)
		(!ctrl_ff[`DTC_CTRL_XA_TYPE] && tick && !(wr && hit_ctrl)) |=> ctrl_ff[`DTC_CTRL_XA_FLAG] == !$past(sync2_ff[0]);
	endproperty
	a_level_follows: assert property (p_level_follows) else $error("level flag wrong"); // RQ4
	property p_gate_blocks;
		@(posedge pclk) disable iff (!presetn)
		(mode_ff[3] && !sync2_ff[0]) |-> !ev_a;
	endproperty
	a_gate_blocks: assert property (p_gate_blocks) else $error("gated timer counted"); // RQ6
	property p_reload;
		@(posedge pclk) disable iff (!presetn)
		(ev_a && mode_a == DTC_MODE_RELOAD && a_lo_ff == 8'hff && !wr) |=> a_lo_ff == a_hi_ff;
	endproperty
	a_reload: assert property (p_reload) else $error("reload wrong"); // RQ9
	property p_b_hold;
		@(posedge pclk) disable iff (!presetn)
		(mode_b == DTC_MODE_SPLIT && !(wr && (hit_blo || hit_bhi))) |=> $stable(b_lo_ff) && $stable(b_hi_ff);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("timer b ran in mode 3"); // RQ12
	property p_tick_period;
		@(posedge pclk) disable iff (!presetn)
		(tick && div_ff == 8'h02 && !(wr && hit_div)) |=> !tick ##1 !tick ##1 tick;
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("machine cycle period wrong"); // RQ14
	property p_irq_level;
		@(posedge pclk) disable iff (!presetn)
		irq == |(stat_ff & mask_ff);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq mismatch");
	property p_ovf_sets_ta;
		@(posedge pclk) disable iff (!presetn)
		set_ta |=> ctrl_ff[`DTC_CTRL_A_OVF];
	endproperty
	a_ovf_sets_ta: assert property (p_ovf_sets_ta) else $error("timer a overflow flag not set"); // RQ1
	property p_count_16;
		@(posedge pclk) disable iff (!presetn)
		(ev_a && mode_a == DTC_MODE_16BIT && !wr) |=> {a_hi_ff, a_lo_ff} == $past({a_hi_ff, a_lo_ff}) + 16'h0001;
	endproperty
	a_count_16: assert property (p_count_16) else $error("16-bit count step wrong"); // RQ8 RQ16
	property p_prescale_carry;
		@(posedge pclk) disable iff (!presetn)
		(ev_a && mode_a == DTC_MODE_13BIT && a_lo_ff[4:0] == 5'h1f && !wr) |=>
			a_lo_ff[4:0] == 5'h00 && a_hi_ff == $past(a_hi_ff) + 8'h01;
	endproperty
	a_prescale_carry: assert property (p_prescale_carry) else $error("prescaler carry wrong"); // RQ8
	property p_split_high;
		@(posedge pclk) disable iff (!presetn)
		(split && ev_ah && a_hi_ff == 8'hff) |=> ctrl_ff[`DTC_CTRL_B_OVF];
	endproperty
	a_split_high: assert property (p_split_high) else $error("split high byte flag missed"); // RQ11
	property p_ext_ack;
		@(posedge pclk) disable iff (!presetn)
		(ack[0] && ctrl_ff[`DTC_CTRL_XA_TYPE] && !set_xa) |=> !ctrl_ff[`DTC_CTRL_XA_FLAG];
	endproperty
	a_ext_ack: assert property (p_ext_ack) else $error("edge flag not cleared"); // RQ3
	property p_count_src;
		@(posedge pclk) disable iff (!presetn)
		(mode_ff[`DTC_MODE_A_PIN] && !(tick && fall[2])) |-> !ev_a;
	endproperty
	a_count_src: assert property (p_count_src) else $error("counter moved without pin edge"); // RQ7 RQ15
	c_ovf_a: cover property (@(posedge pclk) disable iff (!presetn) set_ta);
	c_split_b: cover property (@(posedge pclk) disable iff (!presetn) split && ovf_ah);
	c_edge: cover property (@(posedge pclk) disable iff (!presetn) set_xa);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);
	c_reload: cover property (@(posedge pclk) disable iff (!presetn) ev_a && mode_a == DTC_MODE_RELOAD && a_lo_ff == 8'hff);
endmodule
`default_nettype wire
